// ===== include/qser_cfg.svh
// Offsets, field positions, reset values and timing counts of the queued serial master.
// Assumes a word-indexed register port; each offset below is an index, not a byte address.
`ifndef QSER_CFG_SVH
`define QSER_CFG_SVH
// Register indices
`define QSER_OFS_MODE    8'h00
`define QSER_OFS_DELAYS  8'h01
`define QSER_OFS_QUEUE   8'h02
`define QSER_OFS_TEST    8'h03
`define QSER_OFS_STATUS  8'h04
`define QSER_OFS_DIR     8'h05
`define QSER_OFS_DATA    8'h06
`define QSER_OFS_ASSIGN  8'h07
// Queue RAM windows, upper nibble selects the part, lower nibble the entry
`define QSER_WIN_RX      4'h1
`define QSER_WIN_TX      4'h2
`define QSER_WIN_CMD     4'h3
// Mode register fields
`define QSER_MODE_MASTER_SELECT   15
`define QSER_MODE_ODS    14
`define QSER_MODE_BITS_H 13
`define QSER_MODE_BITS_L 10
`define QSER_MODE_CPOL   9
`define QSER_MODE_CPHA   8
// Delay, queue and status register fields
`define QSER_DLY_ENABLE  15
`define QSER_Q_FIE       15
`define QSER_Q_WRAP      14
`define QSER_Q_WRAP_TARGET_SELECT      13
`define QSER_ST_FIN      7
// Command byte fields
`define QSER_CMD_HOLD    7
`define QSER_CMD_LSEL    6
`define QSER_CMD_PDLY    5
`define QSER_CMD_CDLY    4
// Reset values
`define QSER_RST_MODE    16'h0000
`define QSER_RST_DELAYS  16'h0404
`define QSER_RST_QUEUE   16'h0000
`define QSER_RST_PINS    8'h00
// Timing counts in system clock cycles, then word lengths in bits
`define QSER_MIN_HALF    8'h02
`define QSER_GAP_UNIT    14'h0020
`define QSER_DEF_LEN     5'h08
`define QSER_MAX_LEN     5'h10
`endif

// ===== include/qser_pkg.sv
// Types shared by the queued serial master.
// Assumes qser_cfg.svh carries all numeric constants.
package qser_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_LEAD, ST_SHIFT, ST_TRAIL, ST_GAP, ST_NEXT}
    qser_state_t;
  typedef logic [3:0] qser_ptr_t;
endpackage : qser_pkg

// ===== core/qser_master.sv
// Queued serial master: register port, queue RAM, transfer engine and pin muxing.
// Assumes a single 25 MHz clock, synchronous inputs and a one-cycle strobe register master.
`include "qser_cfg.svh"

module qser_master
  import qser_pkg::*;
#(
  parameter int ENTRIES = 16,
  parameter int NPINS   = 7
)(
  input  wire logic             REF_CLK,
  input  wire logic             NRST,
  input  wire logic [7:0]       ADDR,
  input  wire logic [15:0]      WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [15:0]      RDATA,
  input  wire logic [NPINS-1:0] PIN_I,
  output logic      [NPINS-1:0] PIN_O,
  output logic      [NPINS-1:0] PIN_OE,
  output logic                  IRQ
);

  // Pin order: 0 data in, 1 data out, 2 serial clock, 3..6 selects
  logic [15:0]     mode_r;
  logic [15:0]     delays_r;
  logic [15:0]     queue_r;
  logic [7:0]      test_r;
  logic            fin_flag;
  qser_ptr_t       cpt_ptr;
  logic [7:0]      dir_r;
  logic [7:0]      data_r;
  logic [7:0]      assign_r;
  logic [15:0]     tx_mem [ENTRIES];
  logic [15:0]     rx_mem [ENTRIES];
  logic [7:0]      cmd_mem [ENTRIES];
  qser_state_t     st;
  qser_ptr_t       ptr;
  logic [13:0]     cnt;
  logic [4:0]      len;
  logic [5:0]      ec;
  logic [15:0]     sh;
  logic [15:0]     rx_sh;
  logic            sck_q;
  logic [3:0]      pcs_q;
  logic            hold;
  logic [7:0]      half;
  logic [4:0]      field_len;
  logic            enable;
  logic            master;
  logic            cpha;
  logic            store;
  logic            stop_wr;
  logic            at_end;
  logic [6:0]      serial_val;
  logic [15:0]     next_rdata;
  qser_ptr_t       newp;
  qser_ptr_t       endp;

  assign enable  = delays_r[`QSER_DLY_ENABLE];
  assign master  = mode_r[`QSER_MODE_MASTER_SELECT];
  assign cpha    = mode_r[`QSER_MODE_CPHA];
  assign newp    = queue_r[3:0];
  assign endp    = queue_r[11:8];
  assign at_end  = (ptr == endp);
  assign store   = (st == ST_TRAIL) && (cnt == 14'h0001);
  assign stop_wr = WR && (ADDR == `QSER_OFS_DELAYS) && !WDATA[`QSER_DLY_ENABLE];

  // Half period in system clocks; a floor of two keeps the rate at a quarter
  assign half = (mode_r[7:0] < `QSER_MIN_HALF) ? `QSER_MIN_HALF : mode_r[7:0];

  // An unprogrammed length selects 16 bits; short lengths fall back to 8
  always_comb
  begin
    if (mode_r[`QSER_MODE_BITS_H:`QSER_MODE_BITS_L] == 4'h0)
      field_len = `QSER_MAX_LEN;
    else if (mode_r[`QSER_MODE_BITS_H:`QSER_MODE_BITS_L] < 4'h8)
      field_len = `QSER_DEF_LEN;
    else
      field_len = {1'b0, mode_r[`QSER_MODE_BITS_H:`QSER_MODE_BITS_L]};
  end

  // Control registers written from the port
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      mode_r   <= `QSER_RST_MODE;
      queue_r  <= `QSER_RST_QUEUE;
      test_r   <= `QSER_RST_PINS;
      dir_r    <= `QSER_RST_PINS;
      data_r   <= `QSER_RST_PINS;
      assign_r <= `QSER_RST_PINS;
    end
    else if (WR)
    begin
      unique case (ADDR)
        `QSER_OFS_MODE:   mode_r   <= WDATA;
        `QSER_OFS_QUEUE:  queue_r  <= WDATA;
        `QSER_OFS_TEST:   test_r   <= WDATA[7:0];
        `QSER_OFS_DIR:    dir_r    <= WDATA[7:0];
        `QSER_OFS_DATA:   data_r   <= WDATA[7:0];
        `QSER_OFS_ASSIGN: assign_r <= WDATA[7:0];
        default:          ;
      endcase
    end
  end

  // Enable and delays; a software write wins over the self-clear
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      delays_r <= `QSER_RST_DELAYS;
    else if (WR && ADDR == `QSER_OFS_DELAYS)
      delays_r <= WDATA;
    else if (st == ST_NEXT && at_end && !queue_r[`QSER_Q_WRAP])
      delays_r[`QSER_DLY_ENABLE] <= 1'b0;
  end

  // Status: completion sets the flag, and a set beats a same-cycle clear
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      fin_flag <= 1'b0;
      cpt_ptr  <= '0;
    end
    else
    begin
      if (store)
        cpt_ptr <= ptr;
      if (store && at_end)
        fin_flag <= 1'b1;
      else if (WR && ADDR == `QSER_OFS_STATUS && WDATA[`QSER_ST_FIN])
        fin_flag <= 1'b0;
    end
  end

  // Queue RAM: transmit and command from software, receive from the engine
  always_ff @(posedge REF_CLK)
  begin
    if (WR && ADDR[7:4] == `QSER_WIN_TX)
      tx_mem[ADDR[3:0]] <= WDATA;
    if (WR && ADDR[7:4] == `QSER_WIN_CMD)
      cmd_mem[ADDR[3:0]] <= WDATA[7:0];
    if (store)
      rx_mem[ptr] <= rx_sh;
  end

  // Transfer engine; clearing enable aborts from any state
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      st    <= ST_IDLE;
      ptr   <= '0;
      cnt   <= '0;
      len   <= `QSER_DEF_LEN;
      ec    <= '0;
      sh    <= '0;
      rx_sh <= '0;
      sck_q <= 1'b0;
      pcs_q <= 4'h0;
      hold  <= 1'b0;
    end
    else if (!enable || stop_wr || !master)
    begin
      st    <= ST_IDLE;
      sck_q <= mode_r[`QSER_MODE_CPOL];
      pcs_q <= data_r[6:3];
      hold  <= 1'b0;
    end
    else
    begin
      unique case (st)
        ST_IDLE:
        begin
          ptr   <= newp;
          sck_q <= mode_r[`QSER_MODE_CPOL];
          st    <= ST_LOAD;
        end
        ST_LOAD:
        begin
          pcs_q <= cmd_mem[ptr][3:0];
          hold  <= cmd_mem[ptr][`QSER_CMD_HOLD];
          len   <= cmd_mem[ptr][`QSER_CMD_LSEL] ? field_len : `QSER_DEF_LEN;
          sh    <= tx_mem[ptr] << (5'h10 - (cmd_mem[ptr][`QSER_CMD_LSEL] ?
                   field_len : `QSER_DEF_LEN));
          rx_sh <= '0;
          ec    <= '0;
          // Count starts one short: the hand-over to shifting is the last lead cycle
          // Limitation: a programmed delay of one still takes two cycles
          if (cmd_mem[ptr][`QSER_CMD_CDLY])
            cnt <= (delays_r[14:8] == 7'h00) ? 14'h007F :
                   {7'h00, delays_r[14:8]} - 14'h0001;
          else
            cnt <= {6'h00, half} - 14'h0001;
          st    <= ST_LEAD;
        end
        ST_LEAD:
        begin
          if (cnt <= 14'h0001)
          begin
            cnt <= 14'h0001;
            st  <= ST_SHIFT;
          end
          else
            cnt <= cnt - 14'h0001;
        end
        ST_SHIFT:
        begin
          if (cnt == 14'h0001)
          begin
            // Even edge count is the leading edge of a clock pulse
            sck_q <= !sck_q;
            ec    <= ec + 6'h01;
            cnt   <= {6'h00, half};
            if (ec[0] == cpha)
              rx_sh <= {rx_sh[14:0], PIN_I[0]};
            else if (!(cpha && ec == 6'h00))
              sh <= {sh[14:0], 1'b0};
            if (ec == {len, 1'b0} - 6'h01)
              st <= ST_TRAIL;
          end
          else
            cnt <= cnt - 14'h0001;
        end
        ST_TRAIL:
        begin
          if (cnt == 14'h0001)
          begin
            if (!hold)
              pcs_q <= data_r[6:3];
            if (cmd_mem[ptr][`QSER_CMD_PDLY])
            begin
              cnt <= (delays_r[7:0] == 8'h00) ? 14'h2000 :
                     {1'b0, delays_r[7:0], 5'h00};
              st  <= ST_GAP;
            end
            else
              st <= ST_NEXT;
          end
          else
            cnt <= cnt - 14'h0001;
        end
        ST_GAP:
        begin
          if (cnt == 14'h0001)
            st <= ST_NEXT;
          else
            cnt <= cnt - 14'h0001;
        end
        ST_NEXT:
        begin
          if (!at_end)
          begin
            ptr <= ptr + 4'h1;
            st  <= ST_LOAD;
          end
          else if (queue_r[`QSER_Q_WRAP])
          begin
            ptr <= queue_r[`QSER_Q_WRAP_TARGET_SELECT] ? newp : 4'h0;
            st  <= ST_LOAD;
          end
          else
            st <= ST_IDLE;
        end
      endcase
    end
  end

  assign serial_val = {pcs_q, sck_q, sh[15], 1'b0};

  // Pin drivers registered; open drain turns a high into a release
  generate
    for (genvar i = 0; i < NPINS; i++)
    begin : g_pin
      logic val;
      assign val = assign_r[i] ? serial_val[i] : data_r[i];
      always_ff @(posedge REF_CLK)
      begin
        if (!NRST)
        begin
          PIN_O[i]  <= 1'b0;
          PIN_OE[i] <= 1'b0;
        end
        else
        begin
          PIN_O[i]  <= mode_r[`QSER_MODE_ODS] ? 1'b0 : val;
          PIN_OE[i] <= dir_r[i] && (!mode_r[`QSER_MODE_ODS] || !val);
        end
      end
    end
  endgenerate

  // Read mux; data reads show pin levels for inputs, latch for outputs
  always_comb
  begin
    next_rdata = 16'h0000;
    unique case (ADDR)
      `QSER_OFS_MODE:   next_rdata = mode_r;
      `QSER_OFS_DELAYS: next_rdata = delays_r;
      `QSER_OFS_QUEUE:  next_rdata = queue_r;
      `QSER_OFS_TEST:   next_rdata = {8'h00, test_r};
      `QSER_OFS_STATUS: next_rdata = {8'h00, fin_flag, 3'h0, cpt_ptr};
      `QSER_OFS_DIR:    next_rdata = {8'h00, dir_r};
      `QSER_OFS_DATA:   next_rdata = {8'h00, (dir_r & data_r) | (~dir_r & {1'b0, PIN_I})};
      `QSER_OFS_ASSIGN: next_rdata = {8'h00, assign_r};
      default:
      begin
        if (ADDR[7:4] == `QSER_WIN_RX)
          next_rdata = rx_mem[ADDR[3:0]];
        else if (ADDR[7:4] == `QSER_WIN_TX)
          next_rdata = tx_mem[ADDR[3:0]];
        else if (ADDR[7:4] == `QSER_WIN_CMD)
          next_rdata = {8'h00, cmd_mem[ADDR[3:0]]};
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      RDATA <= 16'h0000;
    else
      RDATA <= RD ? next_rdata : 16'h0000;
  end

  // Interrupt follows the finished flag under its enable
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      IRQ <= 1'b0;
    else
      IRQ <= fin_flag && queue_r[`QSER_Q_FIE];
  end

  // Checks on the engine and status
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  a_sck_quarter: assert property (
    (st == ST_SHIFT && !stop_wr && $changed(sck_q)) |=> !$changed(sck_q))
    else $error("Serial clock toggled on consecutive cycles");
  a_pcs_load: assert property (
    (st == ST_LOAD && enable && master && !stop_wr) |=> pcs_q == $past(cmd_mem[ptr][3:0]))
    else $error("Select pattern not loaded from entry");
  a_pcs_hold: assert property (
    (store && hold && enable && !stop_wr) |=> pcs_q == $past(pcs_q))
    else $error("Held select changed after transfer");
  a_pcs_default: assert property (
    (store && !hold && enable && master && !stop_wr) |=> pcs_q == $past(data_r[6:3]))
    else $error("Default select not driven");
  a_len_default: assert property (
    (st == ST_LOAD && enable && master && !stop_wr && !cmd_mem[ptr][`QSER_CMD_LSEL])
    |=> len == `QSER_DEF_LEN)
    else $error("Default length not eight");
  a_stop_now: assert property (
    stop_wr |=> st == ST_IDLE)
    else $error("Clearing enable did not halt");
  a_self_clear: assert property (
    (st == ST_NEXT && at_end && !queue_r[`QSER_Q_WRAP] && !WR && enable && master)
    |=> !enable ##1 st == ST_IDLE)
    else $error("Enable not cleared at queue end");
  a_wrap_target: assert property (
    (st == ST_NEXT && at_end && queue_r[`QSER_Q_WRAP] && enable && master && !stop_wr)
    |=> ptr == ($past(queue_r[`QSER_Q_WRAP_TARGET_SELECT]) ? $past(newp) : 4'h0))
    else $error("Wrap went to wrong entry");
  a_fin_flag: assert property (
    (store && at_end) |=> fin_flag && cpt_ptr == $past(ptr) ##1 IRQ == queue_r[`QSER_Q_FIE])
    else $error("Finished flag or completed pointer wrong");
  a_rx_store: assert property (
    store |=> rx_mem[$past(ptr)] == $past(rx_sh))
    else $error("Received word not stored in entry");
  a_gap_len: assert property (
    (st == ST_GAP && $past(st) == ST_TRAIL && enable && master)
    |-> cnt[4:0] == 5'h00)
    else $error("Post delay not a multiple of 32");

  c_wrap: cover property (st == ST_NEXT && at_end && queue_r[`QSER_Q_WRAP]);
  c_gap: cover property (st == ST_GAP);
  c_lead_dly: cover property (st == ST_LOAD && cmd_mem[ptr][`QSER_CMD_CDLY]);
  c_open_drain: cover property (mode_r[`QSER_MODE_ODS] && st == ST_SHIFT);

endmodule : qser_master

// ===== testbench/qser_periph_model.sv
// Peripheral model on select line 0 of the queued serial master.
// Samples on the rising clock and shifts on the falling one: right for mode 0; in mode 3 the first fall drops reply bit 31.
// Assumes an active-low select and a pull-up on its data output line.
module qser_periph_model (
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic [31:0] reply,
  output logic             miso,
  output logic [31:0]      got,
  output int               frames,
  output time              lead,
  output time              period,
  output time              gap
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] sh;
  time         t_sel = 0;
  time         t_rise = 0;
  time         t_des = 0;

  // A released line goes to its pull-up level, never a stale copy
  assign miso = sel_n ? 1'b1 : sh[31];

  initial
  begin
    got = '0;
    frames = 0;
  end

  // Reply loads on select; gap runs from the last deselect
  always @(negedge sel_n)
  begin
    sh = reply;
    t_sel = $time;
    gap = $time - t_des;
  end

  always @(posedge sel_n)
  begin
    frames = frames + 1;
    t_des = $time;
  end

  // Sample on the rising edge; first rise of a frame gives the lead time
  always @(posedge sck)
  begin
    if (!sel_n)
    begin
      got = {got[30:0], mosi};
      if (t_rise < t_sel)
        lead = $time - t_sel;
      else
        period = $time - t_rise;
      t_rise = $time;
    end
  end

  // Shift on the falling edge so data is steady at the next rise
  always @(negedge sck)
  begin
    if (!sel_n)
    begin
      sh = {sh[30:0], 1'b0};
    end
  end
endmodule : qser_periph_model

// ===== testbench/tb_top.sv
// Self-checking bench for the queued serial master and one peripheral model.
// Assumes pull-ups on every pin and the peripheral on select line 0.
`include "qser_cfg.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        REF_CLK;
  logic        NRST;
  logic [7:0]  ADDR;
  logic [15:0] WDATA;
  logic        WR;
  logic        RD;
  logic [15:0] RDATA;
  logic [6:0]  PIN_I;
  logic [6:0]  PIN_O;
  logic [6:0]  PIN_OE;
  logic        IRQ;
  logic [6:0]  lvl;
  logic        miso;
  logic [31:0] reply;
  logic [31:0] got;
  int          frames;
  time         lead;
  time         period;
  time         gap;
  int          error_cnt;
  int          n_compared;
  int          f0;

  // Released lines float high; data in comes from the peripheral
  assign lvl = (PIN_O & PIN_OE) | ~PIN_OE;
  assign PIN_I = {lvl[6:1], PIN_OE[0] ? PIN_O[0] : miso};

  qser_master dut_u (.REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_I(PIN_I), .PIN_O(PIN_O),
    .PIN_OE(PIN_OE), .IRQ(IRQ));

  qser_periph_model per_u (.sck(PIN_I[2]), .sel_n(PIN_I[3]), .mosi(PIN_I[1]),
    .reply(reply), .miso(miso), .got(got), .frames(frames), .lead(lead),
    .period(period), .gap(gap));

  initial
  begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    @(negedge REF_CLK);
    d = RDATA;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rc

  task automatic go(input logic [15:0] q, input logic [15:0] dl);
    wr(`QSER_OFS_QUEUE, q);
    f0 = frames;
    wr(`QSER_OFS_DELAYS, dl);
  endtask : go

  task automatic wait_sel();
    for (int i = 0; i < 100 && PIN_I[3] !== 1'b0; i++)
      @(negedge REF_CLK);
    chk(PIN_I[3], 1'b0);
  endtask : wait_sel

  // Poll the enable bit; bounded so a stuck engine cannot hang the run
  task automatic wait_idle();
    logic [15:0] d;
    for (int i = 0; i < 400; i++)
    begin
      rd(`QSER_OFS_DELAYS, d);
      if (d[15] === 1'b0)
        break;
    end
    chk(d[15], 1'b0);
  endtask : wait_idle

  task automatic t_reset();
    chk(PIN_OE, 7'h00);
    chk(IRQ, 1'b0);
    rc(`QSER_OFS_MODE, 16'h0000);
    rc(`QSER_OFS_DELAYS, 16'h0404);
    rc(`QSER_OFS_QUEUE, 16'h0000);
    rc(`QSER_OFS_STATUS, 16'h0000);
    rc(`QSER_OFS_ASSIGN, 16'h0000);
    wr(`QSER_OFS_MODE, 16'h8004);
    wr(`QSER_OFS_ASSIGN, 16'h007F);
    wr(`QSER_OFS_DIR, 16'h007E);
    wr(`QSER_OFS_DATA, 16'h0078);
    // Let the default selects reach the pins so the peripheral releases its line
    repeat (2) @(negedge REF_CLK);
    rc(`QSER_OFS_DATA, 16'h0079);
    chk(PIN_OE, 7'h7E);
    chk(PIN_I[6:3], 4'hF);
    $display("reset done");
  endtask : t_reset

  task automatic t_single();
    reply = 32'h3C00_0000;
    wr({`QSER_WIN_TX, 4'h0}, 16'h00A5);
    wr({`QSER_WIN_CMD, 4'h0}, 16'h001E);
    go(16'h0000, 16'h8A00);
    wait_sel();
    chk(PIN_I[6:3], 4'hE);
    wait_idle();
    chk(lead, 400);
    chk(period, 320);
    chk(got[7:0], 8'hA5);
    chk(frames, f0 + 1);
    chk(PIN_I[2], 1'b0);
    rc({`QSER_WIN_RX, 4'h0}, 16'h003C);
    rc(`QSER_OFS_STATUS, 16'h0080);
    rc(`QSER_OFS_DELAYS, 16'h0A00);
    $display("single done");
  endtask : t_single

  // Held select joins two 10-bit words into one frame
  task automatic t_queue();
    reply = 32'hC3A5_F000;
    wr(`QSER_OFS_MODE, 16'hA802);
    wr({`QSER_WIN_TX, 4'h1}, 16'h0155);
    wr({`QSER_WIN_TX, 4'h2}, 16'h02AA);
    wr({`QSER_WIN_CMD, 4'h1}, 16'h00CE);
    wr({`QSER_WIN_CMD, 4'h2}, 16'h004E);
    wr(`QSER_OFS_STATUS, 16'h0080);
    rc(`QSER_OFS_STATUS, 16'h0000);
    go(16'h8201, 16'h8000);
    wait_idle();
    chk(frames, f0 + 1);
    chk(got[19:0], {10'h155, 10'h2AA});
    rc({`QSER_WIN_RX, 4'h1}, {6'h00, reply[31:22]});
    rc({`QSER_WIN_RX, 4'h2}, {6'h00, reply[21:12]});
    rc(`QSER_OFS_STATUS, 16'h0082);
    chk(IRQ, 1'b1);
    wr(`QSER_OFS_STATUS, 16'h0080);
    repeat (3) @(negedge REF_CLK);
    chk(IRQ, 1'b0);
    $display("queue done");
  endtask : t_queue

  task automatic t_pins();
    wr(`QSER_OFS_MODE, 16'h8204);
    repeat (4) @(negedge REF_CLK);
    chk(PIN_I[2], 1'b1);
    wr(`QSER_OFS_MODE, 16'hC004);
    repeat (4) @(negedge REF_CLK);
    chk(PIN_O, 7'h00);
    chk(PIN_OE[6:2], 5'h01);
    wr({`QSER_WIN_RX, 4'h0}, 16'h1234);
    rc({`QSER_WIN_RX, 4'h0}, 16'h003C);
    rc(8'h0F, 16'h0000);
    $display("pins done");
  endtask : t_pins

  // Fastest clock, then enable cleared in mid-word
  task automatic t_abort();
    wr(`QSER_OFS_MODE, 16'h8001);
    wr({`QSER_WIN_TX, 4'h3}, 16'hFFFF);
    wr({`QSER_WIN_CMD, 4'h3}, 16'h004E);
    go(16'h0303, 16'h8000);
    wait_sel();
    repeat (12) @(negedge REF_CLK);
    chk(lead, 80);
    chk(period, 160);
    wr(`QSER_OFS_DELAYS, 16'h0000);
    repeat (4) @(negedge REF_CLK);
    chk(PIN_I[6:2], 5'h1E);
    rc(`QSER_OFS_DELAYS, 16'h0000);
    $display("abort done");
  endtask : t_abort

  task automatic t_gap();
    wr({`QSER_WIN_TX, 4'h4}, 16'h005A);
    wr({`QSER_WIN_TX, 4'h5}, 16'h00C3);
    wr({`QSER_WIN_CMD, 4'h4}, 16'h002E);
    wr({`QSER_WIN_CMD, 4'h5}, 16'h000E);
    go(16'h0504, 16'h8001);
    wait_idle();
    chk(frames, f0 + 2);
    chk(got[15:0], 16'h5AC3);
    chk(gap >= 1280 && gap <= 1600, 1'b1);
    $display("gap done");
  endtask : t_gap

  // Mode 3 words from two entries, wrapping back to the new pointer until stopped
  task automatic t_wrap();
    logic [31:0] g;
    wr(`QSER_OFS_MODE, 16'h8304);
    wr({`QSER_WIN_TX, 4'h6}, 16'h0081);
    wr({`QSER_WIN_TX, 4'h7}, 16'h007E);
    wr({`QSER_WIN_CMD, 4'h6}, 16'h000E);
    wr({`QSER_WIN_CMD, 4'h7}, 16'h000E);
    wr(`QSER_OFS_STATUS, 16'h0080);
    go(16'h6706, 16'h8000);
    for (int i = 0; i < 1000 && frames < f0 + 3; i++)
      @(negedge REF_CLK);
    g = got;
    chk(frames, f0 + 3);
    wr(`QSER_OFS_DELAYS, 16'h0000);
    repeat (4) @(negedge REF_CLK);
    chk(g[23:0], 24'h817E81);
    chk(PIN_I[2], 1'b1);
    rc(`QSER_OFS_STATUS, 16'h0086);
    $display("wrap done");
  endtask : t_wrap

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // Watchdog: the tests need well under a tenth of this span
  initial
  begin
    #400us;
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    NRST = 1'b0;
    ADDR = 8'h00;
    WDATA = 16'h0000;
    WR = 1'b0;
    RD = 1'b0;
    reply = 32'h0000_0000;
    error_cnt = 0;
    n_compared = 0;
    f0 = 0;
    repeat (8) @(posedge REF_CLK);
    NRST <= 1'b1;
    t_reset();
    t_single();
    t_queue();
    t_pins();
    t_abort();
    t_gap();
    t_wrap();
    wrap_up();
  end
endmodule : tb_top
